// [bench/mmlac_core_monitor.sv]
/*
 * checker for the memory map and lock access control block
 * assumes it is bound to mmlac_core and sees only its ports
 */
`timescale 1ns/100ps
`include "mmlac_consts.svh"

module mmlac_core_chk
	import mmlac_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	input wire logic clk_en,
	// request and answer
	input wire mmlac_req_s req,
	input wire mmlac_rsp_s rsp,
	// state
	input wire logic locked,
	input wire logic fuses_loaded,
	input wire logic [8*`MMLAC_FUSE_CNT-1:0] fuse_active,
	input wire logic [31:0] scratch_bytes
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	logic take;
	assign take = req.valid && clk_en;

	property p_answer;
		take |=> rsp.granted != rsp.denied;
	endproperty
	a_answer: assert property (p_answer) else $error("no single answer");
	property p_dbg_lock;
		take && req.from_dbg && locked && req.op == MMLAC_OP_RD
			&& req.space != MMLAC_SP_SIB |=> rsp.denied;
	endproperty
	a_dbg_lock: assert property (p_dbg_lock) else $error("locked read");
	property p_corrupt;
		take && req.from_dbg && req.op == MMLAC_OP_RD ##1 rsp.denied
			|-> rsp.rdata == `MMLAC_CORRUPT_BYTE;
	endproperty
	a_corrupt: assert property (p_corrupt) else $error("clean data");
	property p_sig_ro;
		take && req.space == MMLAC_SP_SIG && req.op != MMLAC_OP_RD
			|=> rsp.denied;
	endproperty
	a_sig_ro: assert property (p_sig_ro) else $error("sig altered");
	property p_fuse_core;
		take && !req.from_dbg && req.space == MMLAC_SP_FUSE
			&& req.op != MMLAC_OP_RD |=> rsp.denied;
	endproperty
	a_fuse_core: assert property (p_fuse_core) else $error("core fuse");
	property p_start;
		$fell(rst) |-> scratch_bytes == 32'h0 && !fuses_loaded
			##1 fuses_loaded;
	endproperty
	a_start: assert property (p_start) else $error("start state");
	// a fuse write must not reach the active copy before a reset
	property p_fuse_hold;
		!$past(rst) && !$past(rst, 2) |-> $stable(fuse_active);
	endproperty
	a_fuse_hold: assert property (p_fuse_hold) else $error("fuse moved");
	property p_lock_code;
		take && req.from_dbg && req.space == MMLAC_SP_FUSE
			&& fuse_active[8*`MMLAC_LOCK_IDX+:8] != `MMLAC_UNLOCK_CODE
			|=> rsp.denied;
	endproperty
	a_lock_code: assert property (p_lock_code) else $error("lock");
	property p_bit_set;
		take && !req.from_dbg && req.op == MMLAC_OP_BSET
			&& req.space == MMLAC_SP_IO && req.addr == 16'h001c
			|=> scratch_bytes[7:0] == ($past(scratch_bytes[7:0])
			| (8'h01 << $past(req.bit_sel)));
	endproperty
	a_bit_set: assert property (p_bit_set) else $error("bit set");
endmodule : mmlac_core_chk

bind mmlac_core mmlac_core_chk chk_u (.clock(clock), .rst(rst),
	.clk_en(clk_en), .req(req), .rsp(rsp), .locked(locked),
	.fuses_loaded(fuses_loaded), .fuse_active(fuse_active),
	.scratch_bytes(scratch_bytes));

// [bench/mmlac_far_model.sv]
/*
 * memory subsystem seen by the access control block
 * assumes requests are held for a cycle by the requester
 */
`timescale 1ns/100ps

module mmlac_far_model
	import mmlac_pkg::*;
(
	// clock
	input wire logic clock,
	// request and byte answered in the same cycle
	input wire mmlac_req_s req,
	output logic [7:0] mem_rdata
);
	logic [7:0] idle_ff = 8'h00;
	always @(posedge clock)
		idle_ff <= idle_ff + 8'h01;
	// one byte per address
	// idle bus toggles so stale data never passes for an answer
	assign mem_rdata = req.valid ? (req.addr[7:0] ^ 8'h3c) : ~idle_ff;
endmodule : mmlac_far_model

// [bench/tb_memory_map_lock_access_control.sv]
/*
 * self checking bench for the memory map and lock block
 * assumes the design, package and far model are compiled first
 */
`timescale 1ns/100ps

module tb_memory_map_lock_access_control
	import mmlac_pkg::*;
;
	typedef struct packed {
		logic [1:0] gd;
		logic cd;
		logic [7:0] d;
		logic [7:0] ma;
	} mmlac_exp_s;
	localparam logic [1:0] G = 2'b10;
	localparam logic [1:0] D = 2'b01;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic clk_en = 1'b1;
	logic full_erase_command = 1'b0;
	logic [7:0] boot_section_end = 8'h02;
	logic [7:0] app_code_end = 8'h04;
	mmlac_req_s req = '0;
	mmlac_rsp_s rsp;
	logic [7:0] mem_rdata;
	logic locked;
	logic [12:0] pc_word;
	mmlac_exp_s expq[$];
	mmlac_exp_s e;
	int mismatches = 0;
	int compares = 0;
	int cycles = 0;
	logic [7:0] v;
	logic [2:0] b;
	logic [15:0] a;
	logic [15:0] pc = 16'h8100;
	logic [7:0] sig [3] = '{8'h5a, 8'h3c, 8'h69};
	logic [15:0] spc [5] = '{16'h8100, 16'h8300, 16'h8300, 16'h8500, 16'h8500};
	logic [15:0] sdst [5] = '{16'h8300, 16'h8500, 16'h8300, 16'h8600, 16'h1400};
	logic [1:0] sgd [5] = '{G, G, D, D, D};

	initial forever #25 clock = ~clock;

	// signature bytes are arbitrary
	mmlac_core #(.FLASH_WORDS(8192), .SIG_BYTE0(8'h5a), .SIG_BYTE1(8'h3c),
		.SIG_BYTE2(8'h69)) dut_u (.clock(clock), .rst(rst), .clk_en(clk_en),
		.req(req), .rsp(rsp), .mem_rdata(mem_rdata),
		.full_erase_command(full_erase_command),
		.boot_section_end(boot_section_end), .app_code_end(app_code_end),
		.locked(locked), .fuses_loaded(), .fuse_active(),
		.scratch_bytes(), .pc_word(pc_word));
	mmlac_far_model far_u (.clock(clock), .req(req), .mem_rdata(mem_rdata));

	task automatic check(input string nm, input logic [7:0] seen, exp);
		compares++;
		if (seen !== exp)
		begin
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
			mismatches++;
		end
	endtask : check

	task automatic conclude;
		if (mismatches == 0 && compares > 0 && expq.size() == 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : conclude

	task automatic issue(input logic dbg, input mmlac_space_e sp,
		input mmlac_op_e op, input logic [15:0] ad, input logic [7:0] wd,
		input logic [1:0] gd, input logic cd, input logic [7:0] d);
		logic [7:0] ma;
		// program loads land from 0x8000 up in data space
		ma = (sp == MMLAC_SP_PGM) ? ad[15:8] + 8'h80 : ad[15:8];
		@(posedge clock);
		req <= '{1'b1, dbg, sp == MMLAC_SP_IO, sp, op, b, ad, wd, pc};
		expq.push_back('{gd, cd, d, ma});
	endtask : issue

	// stored fuses are nonvolatile, so erase and reload them
	task automatic erase_reload;
		@(posedge clock);
		req.valid <= 1'b0;
		full_erase_command <= 1'b1;
		@(posedge clock);
		full_erase_command <= 1'b0;
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
	endtask : erase_reload

	always @(posedge clock)
	begin
		cycles++;
		if (rsp.granted === 1'b1 || rsp.denied === 1'b1)
		begin
			e = expq.size() ? expq.pop_front() : '1;
			check("answer", {6'h0, rsp.granted, rsp.denied}, {6'h0, e.gd});
			check("mem_addr", rsp.mem_addr[15:8], e.ma);
			if (e.cd)
				check("rdata", rsp.rdata, e.d);
		end
		if (cycles == 2000)
		begin
			mismatches++;
			conclude();
		end
	end

	initial
	begin
		void'($urandom(82275));
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		erase_reload();
		check("locked", {7'h0, locked}, 8'h00);
		for (int n = 0; n < 4; n++)
			issue(0, MMLAC_SP_IO, MMLAC_OP_RD, {14'h7, n[1:0]}, 8'h0, G, 1, 8'h0);
		for (int n = 0; n < 4; n++)
		begin
			a = {14'h7, n[1:0]};
			v = 8'($urandom);
			b = 3'($urandom);
			issue(0, MMLAC_SP_IO, MMLAC_OP_WR, a, v, G, 0, 8'h0);
			issue(0, MMLAC_SP_IO, MMLAC_OP_BSET, a, 8'h0, G, 0, 8'h0);
			v = v | (8'h01 << b);
			b = b + 3'd1;
			issue(0, MMLAC_SP_IO, MMLAC_OP_BCLR, a, 8'h0, G, 0, 8'h0);
			issue(0, MMLAC_SP_IO, MMLAC_OP_RD, a, 8'h0, G, 1, v & ~(8'h01 << b));
		end
		for (int n = 0; n < 3; n++)
			issue(n[0], MMLAC_SP_SIG, MMLAC_OP_RD, {14'h0, n[1:0]}, 8'h0, G, 1, sig[n]);
		issue(1, MMLAC_SP_SIG, MMLAC_OP_WR, 16'h0, 8'h0, D, 0, 8'h0);
		issue(0, MMLAC_SP_FUSE, MMLAC_OP_WR, 16'hf, 8'h0, D, 0, 8'h0);
		issue(1, MMLAC_SP_DATA, MMLAC_OP_RD, 16'h8000, 8'h0, G, 0, 8'h0);
		issue(0, MMLAC_SP_PGM, MMLAC_OP_RD, 16'h10, 8'h0, G, 1, 8'h2c);
		issue(0, MMLAC_SP_IO, MMLAC_OP_RD, 16'h40, 8'h0, D, 0, 8'h0);
		issue(0, MMLAC_SP_DATA, MMLAC_OP_RD, 16'h40, 8'h0, G, 1, 8'h7c);
		issue(0, MMLAC_SP_IO, MMLAC_OP_BSET, 16'h20, 8'h0, D, 0, 8'h0);
		issue(1, MMLAC_SP_FUSE, MMLAC_OP_WR, 16'h1, 8'hfe, G, 0, 8'h0);
		issue(1, MMLAC_SP_FUSE, MMLAC_OP_RD, 16'h1, 8'h0, G, 1, 8'hfe);
		issue(0, MMLAC_SP_IO, MMLAC_OP_WR, 16'h1c, 8'h33, G, 0, 8'h0);
		@(posedge clock);
		req.valid <= 1'b0;
		// a write presented while clk_en is low must not land
		@(posedge clock);
		clk_en <= 1'b0;
		req <= '{1'b1, 1'b0, 1'b1, MMLAC_SP_IO, MMLAC_OP_WR, b, 16'h1c,
			8'hcc, pc};
		repeat (2) @(posedge clock);
		clk_en <= 1'b1;
		req.valid <= 1'b0;
		issue(0, MMLAC_SP_IO, MMLAC_OP_RD, 16'h1c, 8'h0, G, 1, 8'h33);
		for (int n = 0; n < 5; n++)
		begin
			pc = spc[n];
			issue(0, MMLAC_SP_DATA, MMLAC_OP_WR, sdst[n], 8'h11, sgd[n], 0, 8'h0);
		end
		pc = 16'h8100;
		issue(1, MMLAC_SP_FUSE, MMLAC_OP_WR, 16'hf, 8'h0, G, 0, 8'h0);
		@(posedge clock);
		req.valid <= 1'b0;
		check("pc_word", {3'h0, pc_word[12:8]}, 8'h01);
		repeat (2) @(posedge clock);
		check("locked", {7'h0, locked}, 8'h00);
		@(posedge clock);
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
		check("locked", {7'h0, locked}, 8'h01);
		issue(1, MMLAC_SP_DATA, MMLAC_OP_RD, 16'h2000, 8'h0, D, 1, 8'ha5);
		issue(1, MMLAC_SP_SIG, MMLAC_OP_RD, 16'h0, 8'h0, D, 1, 8'ha5);
		issue(1, MMLAC_SP_SIB, MMLAC_OP_RD, 16'h80, 8'h0, G, 1, 8'hbc);
		issue(1, MMLAC_SP_DATA, MMLAC_OP_WR, 16'h1300, 8'h5, G, 0, 8'h0);
		issue(1, MMLAC_SP_DATA, MMLAC_OP_RD, 16'h1300, 8'h0, D, 1, 8'ha5);
		issue(1, MMLAC_SP_FUSE, MMLAC_OP_WR, 16'h0, 8'h0, D, 0, 8'h0);
		issue(0, MMLAC_SP_DATA, MMLAC_OP_RD, 16'h1400, 8'h0, G, 0, 8'h0);
		issue(0, MMLAC_SP_DATA, MMLAC_OP_WR, 16'h1400, 8'h0, D, 0, 8'h0);
		issue(0, MMLAC_SP_DATA, MMLAC_OP_WR, 16'h2000, 8'h0, G, 0, 8'h0);
		issue(0, MMLAC_SP_FUSE, MMLAC_OP_RD, 16'h0, 8'h0, G, 1, 8'hff);
		erase_reload();
		check("locked", {7'h0, locked}, 8'h00);
		conclude();
	end
endmodule : tb_memory_map_lock_access_control

// [verilog/mmlac_consts.svh]
/*
 * constants for the memory map and lock access control block
 * assumes inclusion by the package, the design module and the checker only
 */
`ifndef MMLAC_CONSTS_SVH
`define MMLAC_CONSTS_SVH

// ----------------------------------------------------------------
// data space map
// ----------------------------------------------------------------
`define MMLAC_FLASH_BASE 16'h8000
`define MMLAC_PGM_BASE 16'h0000
`define MMLAC_IO_SHORT_END 16'h003f
`define MMLAC_IO_EXT_LO 16'h0040
`define MMLAC_IO_EXT_HI 16'h0fff
`define MMLAC_BIT_IO_END 16'h001f
`define MMLAC_SCRATCH_BASE 16'h001c
`define MMLAC_EE_BASE 16'h1400
`define MMLAC_EE_END 16'h14ff
`define MMLAC_USER_BASE 16'h1300
`define MMLAC_USER_END 16'h131f
`define MMLAC_SRAM_BASE 16'h2000
`define MMLAC_SRAM_END 16'h3fff
`define MMLAC_SECTION_SHIFT 8

// ----------------------------------------------------------------
// scratch register offsets and reset
// ----------------------------------------------------------------
`define MMLAC_SCRATCH0_OFS 2'h0
`define MMLAC_SCRATCH1_OFS 2'h1
`define MMLAC_SCRATCH2_OFS 2'h2
`define MMLAC_SCRATCH3_OFS 2'h3
`define MMLAC_SCRATCH_RST 8'h00

// ----------------------------------------------------------------
// signature space, lock and fuse defaults
// ----------------------------------------------------------------
`define MMLAC_SIG_LAST 8'h02
`define MMLAC_SIB_BASE 8'h80
`define MMLAC_UNLOCK_CODE 8'hc5
`define MMLAC_LOCK_ERASED 8'hc5
`define MMLAC_FUSE_ERASED 8'hff
`define MMLAC_FUSE_CNT 16
`define MMLAC_LOCK_IDX 4'hf
`define MMLAC_CORRUPT_BYTE 8'ha5

`endif

// [verilog/mmlac_core.sv]
/*
 * memory map decoding, lock based access control, fuse shadow with
 * load at reset, and the four bit addressable scratch registers.
 * assumes one 20 MHz clock, synchronous inputs, a memory subsystem
 * that returns read data on mem_rdata in the request cycle, and one
 * request per cycle from the core or the debug port.
 */
`timescale 1ns/100ps
`include "mmlac_consts.svh"

// Overview of operation
// - flash is 16-bit words, 12/13-bit counter
// - data access flash at 0x8000, pgm load 0
// - self writes only into higher sections
// - eeprom and settings page byte wide
// - debug writes settings page when locked
// - three byte signature at 0x00-0x02
// - locked debug sees only info block
// - short io 0x00-0x3f single cycle
// - extended io only via load/store
// - bit ops below 0x20, one bit only
// - four scratch bytes at 0x1c, reset zero
// - any non-unlock lock value locks
// - unlocked debug full access, signature read only
// - locked debug denied all but settings write and info block
// - locked core keeps documented access
// - denied debug read returns corrupt data
// - locked settings page written blind
// - only full erase unlocks device
// - only debug port programs fuses
// - fuses copied out after start-up
// - fuse changes apply after next reset
// - signature row never altered

module mmlac_core
	import mmlac_pkg::*;
#(
	parameter int FLASH_WORDS = 8192,
	parameter logic [7:0] SIG_BYTE0 = 8'h5a,
	parameter logic [7:0] SIG_BYTE1 = 8'h3c,
	parameter logic [7:0] SIG_BYTE2 = 8'h69
)
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	input wire logic clk_en,
	// request and answer
	input wire mmlac_req_s req,
	output mmlac_rsp_s rsp,
	input wire logic [7:0] mem_rdata,
	// debug port erase command
	input wire logic full_erase_command,
	// section fields from the fuses
	input wire logic [7:0] boot_section_end,
	input wire logic [7:0] app_code_end,
	// state seen by the rest of the chip
	output logic locked,
	output logic fuses_loaded,
	output logic [8*`MMLAC_FUSE_CNT-1:0] fuse_active,
	output logic [31:0] scratch_bytes,
	output logic [$clog2(FLASH_WORDS)-1:0] pc_word
);

	localparam int PCW = $clog2(FLASH_WORDS);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0] scratch_ff [4];
	logic [7:0] fuse_nv_ff [`MMLAC_FUSE_CNT];
	logic [7:0] fuse_act_ff [`MMLAC_FUSE_CNT];
	logic loaded_ff;
	mmlac_rsp_s rsp_ff;
	mmlac_rsp_s nxt_rsp;
	logic lock_act;
	logic [15:0] boot_lim;
	logic [15:0] app_lim;
	mmlac_region_e region;
	mmlac_sect_e src_sec;
	mmlac_sect_e dst_sec;
	logic is_wr;
	logic ok;
	logic [1:0] sidx;
	logic is_scratch;
	logic [7:0] rd_val;

	assign lock_act = fuse_act_ff[`MMLAC_LOCK_IDX] != `MMLAC_UNLOCK_CODE;
	assign locked = lock_act;
	assign fuses_loaded = loaded_ff;
	assign rsp = rsp_ff;
	assign pc_word = req.exec_pc[PCW-1:0];

	assign boot_lim = `MMLAC_FLASH_BASE
		+ {boot_section_end, {`MMLAC_SECTION_SHIFT{1'b0}}};
	assign app_lim = (app_code_end != 8'h00) ?
		`MMLAC_FLASH_BASE + {app_code_end, {`MMLAC_SECTION_SHIFT{1'b0}}} :
		16'hffff;

	function automatic mmlac_sect_e sect_of(input logic [15:0] a,
		input logic [15:0] bl, input logic [15:0] al);
		if (a < bl)
			sect_of = MMLAC_SEC_BOOT;
		else if (a < al)
			sect_of = MMLAC_SEC_APPCODE;
		else
			sect_of = MMLAC_SEC_APPDATA;
	endfunction : sect_of

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	always_comb
	begin
		region = MMLAC_R_NONE;
		nxt_rsp = '0;
		nxt_rsp.mem_addr = req.addr;
		is_scratch = 1'b0;
		case (req.space)
			// program load sees flash from zero
			MMLAC_SP_PGM:
			begin
				region = MMLAC_R_FLASH;
				nxt_rsp.mem_addr = req.addr + `MMLAC_FLASH_BASE;
			end
			MMLAC_SP_SIG:
				if (req.addr[7:0] <= `MMLAC_SIG_LAST && req.addr[15:8] == 8'h00)
					region = MMLAC_R_SIG;
			MMLAC_SP_FUSE:
				if (req.addr < 16'(`MMLAC_FUSE_CNT))
					region = MMLAC_R_FUSE;
			MMLAC_SP_SIB:
				region = MMLAC_R_SIB;
			MMLAC_SP_IO:
				if (req.addr <= `MMLAC_IO_SHORT_END)
					region = MMLAC_R_REGS;
			MMLAC_SP_DATA:
				if (req.addr >= `MMLAC_FLASH_BASE)
					region = MMLAC_R_FLASH;
				else if (req.addr >= `MMLAC_SRAM_BASE)
					region = MMLAC_R_SRAM;
				else if (req.addr >= `MMLAC_EE_BASE && req.addr <= `MMLAC_EE_END)
					region = MMLAC_R_EEPROM;
				else if (req.addr >= `MMLAC_USER_BASE
					&& req.addr <= `MMLAC_USER_END)
					region = MMLAC_R_USER;
				else if (req.addr <= `MMLAC_IO_EXT_HI && !req.short_io)
					region = MMLAC_R_REGS;
				else if (req.addr <= `MMLAC_IO_SHORT_END)
					region = MMLAC_R_REGS;
			default:
				region = MMLAC_R_NONE;
		endcase
		// short instructions never reach beyond 0x3f
		if (req.short_io && req.addr > `MMLAC_IO_SHORT_END)
			region = MMLAC_R_NONE;
		is_scratch = region == MMLAC_R_REGS
			&& req.addr[15:2] == `MMLAC_SCRATCH_BASE >> 2;
		nxt_rsp.region = region;
	end

	assign sidx = req.addr[1:0];
	assign is_wr = req.op != MMLAC_OP_RD;
	assign src_sec = sect_of(req.exec_pc, boot_lim, app_lim);
	assign dst_sec = sect_of(nxt_rsp.mem_addr, boot_lim, app_lim);

	// ----------------------------------------------------------------
	// permission check
	// ----------------------------------------------------------------
	always_comb
	begin
		ok = 1'b0;
		if (region == MMLAC_R_NONE)
			ok = 1'b0;
		// bit ops only up to 0x1f
		else if ((req.op == MMLAC_OP_BSET || req.op == MMLAC_OP_BCLR)
			&& !(region == MMLAC_R_REGS && req.addr <= `MMLAC_BIT_IO_END))
			ok = 1'b0;
		else if (req.from_dbg)
		begin
			if (lock_act)
				ok = region == MMLAC_R_SIB
					|| (region == MMLAC_R_USER && is_wr);
			else
				// debug full access; signature read only
				ok = !(is_wr && region == MMLAC_R_SIG);
		end
		else
		begin
			case (region)
				// core keeps its access when locked
				MMLAC_R_SRAM, MMLAC_R_REGS, MMLAC_R_USER, MMLAC_R_SIB:
					ok = 1'b1;
				// self writes only go up the sections
				MMLAC_R_FLASH:
					ok = !is_wr || (src_sec < dst_sec);
				MMLAC_R_EEPROM:
					ok = !is_wr
						|| (!lock_act && src_sec != MMLAC_SEC_APPDATA);
				MMLAC_R_SIG, MMLAC_R_FUSE:
					ok = !is_wr;
				default:
					ok = 1'b0;
			endcase
		end
	end

	// byte reads; denied debug reads corrupted
	always_comb
	begin
		rd_val = mem_rdata;
		case (region)
			MMLAC_R_SIG:
				case (req.addr[1:0])
					2'h0: rd_val = SIG_BYTE0;
					2'h1: rd_val = SIG_BYTE1;
					default: rd_val = SIG_BYTE2;
				endcase
			MMLAC_R_FUSE:
				rd_val = fuse_nv_ff[req.addr[3:0]];
			default:
				if (is_scratch)
					rd_val = scratch_ff[sidx];
		endcase
		if (!ok)
			rd_val = req.from_dbg ? `MMLAC_CORRUPT_BYTE : 8'h00;
	end

	// ----------------------------------------------------------------
	// answer register
	// ----------------------------------------------------------------
	always_ff @(posedge clock)
		if (rst)
			rsp_ff <= '0;
		else if (clk_en)
		begin
			rsp_ff <= nxt_rsp;
			rsp_ff.granted <= req.valid && ok;
			// debug reads complete even when denied
			rsp_ff.denied <= req.valid && !ok;
			rsp_ff.rdata <= req.valid && req.op == MMLAC_OP_RD ? rd_val : 8'h00;
		end

	// ----------------------------------------------------------------
	// scratch bytes
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_scr
			// scratch reset and bit ops; one bit only
			always_ff @(posedge clock)
				if (rst)
					scratch_ff[gi] <= `MMLAC_SCRATCH_RST;
				else if (clk_en && req.valid && ok && is_scratch
					&& sidx == 2'(gi))
					case (req.op)
						MMLAC_OP_WR: scratch_ff[gi] <= req.wdata;
						MMLAC_OP_BSET: scratch_ff[gi][req.bit_sel] <= 1'b1;
						MMLAC_OP_BCLR: scratch_ff[gi][req.bit_sel] <= 1'b0;
						default: scratch_ff[gi] <= scratch_ff[gi];
					endcase
			assign scratch_bytes[8*gi +: 8] = scratch_ff[gi];
		end
	endgenerate

	// ----------------------------------------------------------------
	// fuses: stored copy and active copy
	// ----------------------------------------------------------------
	// stored copy is not cleared by rst: it models nonvolatile cells
	generate
		for (gi = 0; gi < `MMLAC_FUSE_CNT; gi++)
		begin : g_fuse
			always_ff @(posedge clock)
				if (clk_en)
				begin
					// erase restores factory value and unlocks
					if (full_erase_command)
						fuse_nv_ff[gi] <= (gi == `MMLAC_LOCK_IDX) ?
							`MMLAC_LOCK_ERASED : `MMLAC_FUSE_ERASED;
					// only the debug port programs fuses
					else if (req.valid && ok && req.from_dbg
						&& region == MMLAC_R_FUSE && req.op == MMLAC_OP_WR
						&& req.addr[3:0] == 4'(gi))
						fuse_nv_ff[gi] <= req.wdata;
				end
			// copy at end of start-up; only after reset
			always_ff @(posedge clock)
				if (rst)
					fuse_act_ff[gi] <= 8'h00;
				else if (clk_en && !loaded_ff)
					fuse_act_ff[gi] <= fuse_nv_ff[gi];
			assign fuse_active[8*gi +: 8] = fuse_act_ff[gi];
		end
	endgenerate

	always_ff @(posedge clock)
		if (rst)
			loaded_ff <= 1'b0;
		else if (clk_en)
			loaded_ff <= 1'b1;

endmodule : mmlac_core

// [verilog/mmlac_pkg.sv]
/*
 * types of the memory map and lock access control block
 * assumes the constants header sits beside it
 */
`include "mmlac_consts.svh"

package mmlac_pkg;

	// ----------------------------------------------------------------
	// requests and answers
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		MMLAC_SP_DATA,
		MMLAC_SP_PGM,
		MMLAC_SP_IO,
		MMLAC_SP_SIG,
		MMLAC_SP_FUSE,
		MMLAC_SP_SIB
	} mmlac_space_e;

	typedef enum logic [1:0] {
		MMLAC_OP_RD,
		MMLAC_OP_WR,
		MMLAC_OP_BSET,
		MMLAC_OP_BCLR
	} mmlac_op_e;

	typedef enum logic [3:0] {
		MMLAC_R_NONE,
		MMLAC_R_SRAM,
		MMLAC_R_REGS,
		MMLAC_R_FLASH,
		MMLAC_R_EEPROM,
		MMLAC_R_USER,
		MMLAC_R_SIG,
		MMLAC_R_FUSE,
		MMLAC_R_SIB
	} mmlac_region_e;

	typedef enum logic [1:0] {
		MMLAC_SEC_BOOT,
		MMLAC_SEC_APPCODE,
		MMLAC_SEC_APPDATA
	} mmlac_sect_e;

	typedef struct packed {
		logic valid;
		logic from_dbg;
		logic short_io;
		mmlac_space_e space;
		mmlac_op_e op;
		logic [2:0] bit_sel;
		logic [15:0] addr;
		logic [7:0] wdata;
		logic [15:0] exec_pc;
	} mmlac_req_s;

	typedef struct packed {
		logic granted;
		logic denied;
		mmlac_region_e region;
		logic [15:0] mem_addr;
		logic [7:0] rdata;
	} mmlac_rsp_s;

endpackage : mmlac_pkg
